// ==== rtl/rlfc_pkg.sv ====
// Function
// - lockout in remote state blocks front panel except service and channel keys
// - without lockout, front panel commands pass in remote and local
// - dropping remote enable clears lockout automatically
// - remote lamp lit while lockout and remote are both active
// - remote state expects bus commands and shows a remote indicator
// - attention indicator shown while the attention line is low
// - separate listen-addressed and talk-addressed indicators
// - received OUTPUT_HELD_FLAG suspends serial output and sets output held flag
// - received XON resumes serial output
// - nearly full input buffer sends OUTPUT_HELD_FLAG and sets input paused flag
// - more than three characters after our OUTPUT_HELD_FLAG sets the serial error flag
// - serial receive errors set the serial error flag
// - serial input buffer overflow sets the serial error flag
// - serial error flag sticks until debug mode goes off then on
// - debug trace holds recent command characters from both interfaces
// - status and trace stay visible in debug mode whatever menu is shown
// - go-to-local and local-lockout bus messages are both acted on
package rlfc_pkg;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] OUTPUT_HELD_FLAG_CHAR = 8'h13;
  localparam int LATE_CHAR_LIMIT = 3;
  localparam int FILL_HEADROOM = 3;
  localparam int TRACE_DEPTH = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TRACE_BASE = 4'h2;
  localparam int CTRL_DEBUG_BIT = 0;
  localparam int CTRL_MENU_LSB = 1;

  typedef struct packed {
    logic remote;
    logic lockout;
    logic attention;
    logic listen;
    logic talk;
    logic serial_error_flag;
    logic output_held_flag;
    logic input_paused_flag;
  } rlfc_status_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rlfc_char_t;

  typedef enum logic [2:0] {
    RLFC_MSG_NONE,
    RLFC_MSG_GTL,
    RLFC_MSG_LLO
  } rlfc_msg_t;
endpackage

// ==== rtl/rlfc_core.sv ====
`timescale 1ns/1ps
module rlfc_core #(
  parameter int FIFO_DEPTH = 16
) (
  // clock, reset and global enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // instrument bus lines and decoded messages
  input wire logic ren_in,
  input wire logic atn_n_in,
  input wire logic listen_addr_in,
  input wire logic talk_addr_in,
  input wire rlfc_pkg::rlfc_msg_t bus_msg_in,
  input wire rlfc_pkg::rlfc_char_t bus_char_in,
  // raw front panel keys
  input wire logic [9:0] panel_keys_in,
  // serial receive, buffer drain and transmit side
  input wire rlfc_pkg::rlfc_char_t rx_char_in,
  input wire logic rx_err_in,
  input wire logic rx_pop_in,
  input wire logic tx_busy_in,
  input wire rlfc_pkg::rlfc_char_t tx_data_in,
  // register bus slave
  input wire logic [3:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  // gated keys, lamp and indicators
  output logic [9:0] panel_keys_out,
  output logic remote_lamp_out,
  output rlfc_pkg::rlfc_status_t status_out,
  output logic status_visible_out,
  // serial transmit and buffer level
  output rlfc_pkg::rlfc_char_t tx_char_out,
  output logic tx_ready_out,
  output logic [7:0] rx_level_out
);
  import rlfc_pkg::*;

  // flow control thresholds sized to this buffer depth
  localparam logic [7:0] FULL_MARK = 8'(FIFO_DEPTH - FILL_HEADROOM);
  localparam logic [7:0] DEPTH_W = 8'(FIFO_DEPTH);
  localparam logic [7:0] RESUME_MARK = 8'(FIFO_DEPTH / 2);
  localparam logic [2:0] LATE_W = 3'(LATE_CHAR_LIMIT);
  // service key and channel keys survive lockout
  localparam logic [9:0] KEEP_KEYS = 10'h01f;

  // remote interface state
  logic remote_q;
  logic lockout_q;
  // bus line indicators
  logic att_q;
  logic lis_q;
  logic tlk_q;
  // serial flags and debug control
  logic err_q;
  logic held_q;
  logic paused_q;
  logic debug_q;
  logic [1:0] menu_q;
  // input buffer fill and late characters after our output_held_flag
  logic [7:0] level_q;
  logic [2:0] late_q;
  // pending flow characters for the transmitter
  logic send_output_held_flag_q;
  logic send_xon_q;
  // command trace ring
  logic [7:0] trace_q [TRACE_DEPTH];
  logic [3:0] wr_idx_q;
  // register bus slave state
  logic ack_q;
  logic [31:0] rdata_q;
  // registered outputs
  logic [9:0] keys_q;
  logic lamp_q;
  rlfc_char_t tx_q;
  logic txr_q;
  // decoded per-cycle events
  logic rx_data;
  logic rx_push;
  logic new_char;
  logic lockout_on;
  logic late_hit;
  logic tx_done;
  logic ctrl_wr;
  logic [1:0] trace_word;
  rlfc_char_t cmd_char;

  // in-band flow characters are not data
  assign rx_data = rx_char_in.valid && rx_char_in.data != XON_CHAR
                   && rx_char_in.data != OUTPUT_HELD_FLAG_CHAR;
  // a data character is only stored while there is room
  assign rx_push = rx_data && level_q != DEPTH_W;
  // lockout only bites together with remote
  assign lockout_on = lockout_q && remote_q;
  // bus characters take the trace slot when both arrive together
  assign cmd_char = bus_char_in.valid ? bus_char_in : rx_char_in;
  assign new_char = bus_char_in.valid || rx_data;
  // the character beyond the allowed late ones, a single event
  assign late_hit = paused_q && rx_data && !send_output_held_flag_q && late_q == LATE_W;
  // transmitter has taken the character on the output
  assign tx_done = tx_q.valid && !tx_busy_in;
  // control register write taken this cycle
  assign ctrl_wr = avm_write && !ack_q && avm_address == ADDR_CTRL;
  // trace word addressed by the read
  assign trace_word = avm_address[1:0] + 2'h2;

  // remote state and lockout
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end else if (ce_in) begin
      // remote enable dropped: leave remote, cancel lockout
      if (!ren_in) begin
        remote_q <= 1'b0;
        lockout_q <= 1'b0;
      end else begin
        // go-to-local wins over a fresh listen address
        if (bus_msg_in == RLFC_MSG_GTL) begin
          remote_q <= 1'b0;
        end else if (listen_addr_in) begin
          remote_q <= 1'b1;
        end
        // lockout latches until remote enable drops
        if (bus_msg_in == RLFC_MSG_LLO) begin
          lockout_q <= 1'b1;
        end
      end
    end
  end

  // bus line indicators
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      att_q <= 1'b0;
      lis_q <= 1'b0;
      tlk_q <= 1'b0;
    end else if (ce_in) begin
      // attention shown inverted from the active-low line
      att_q <= !atn_n_in;
      // addressing flags follow the decoded lines
      lis_q <= listen_addr_in;
      tlk_q <= talk_addr_in;
    end
  end

  // front panel gating and lamp
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      keys_q <= 10'h000;
      lamp_q <= 1'b0;
    end else if (ce_in) begin
      // bit 0 service request, bits 1..4 channel keys
      keys_q <= lockout_on ? (panel_keys_in & KEEP_KEYS) : panel_keys_in;
      lamp_q <= lockout_on;
    end
  end

  // received XON/OUTPUT_HELD_FLAG pacing of our output
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      held_q <= 1'b0;
    end else if (ce_in && rx_char_in.valid) begin
      // only flow characters change the hold
      if (rx_char_in.data == OUTPUT_HELD_FLAG_CHAR) begin
        held_q <= 1'b1;
      end else if (rx_char_in.data == XON_CHAR) begin
        held_q <= 1'b0;
      end
    end
  end

  // input buffer fill level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_q <= 8'h00;
    end else if (ce_in) begin
      // push and pop together leave a non-empty level alone
      if (rx_push && !(rx_pop_in && level_q != 8'h00)) begin
        level_q <= level_q + 8'h01;
      end else if (!rx_push && rx_pop_in && level_q != 8'h00) begin
        // a pop from an empty buffer is ignored
        level_q <= level_q - 8'h01;
      end
    end
  end

  // our OUTPUT_HELD_FLAG/XON requests and late character count
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      paused_q <= 1'b0;
      send_output_held_flag_q <= 1'b0;
      send_xon_q <= 1'b0;
      late_q <= 3'h0;
    end else if (ce_in) begin
      // buffer nearly full: pause the host
      if (!paused_q && level_q >= FULL_MARK) begin
        paused_q <= 1'b1;
        send_output_held_flag_q <= 1'b1;
        late_q <= 3'h0;
      end else if (paused_q && level_q <= RESUME_MARK && !send_output_held_flag_q) begin
        // drained to half: let the host resume
        paused_q <= 1'b0;
        send_xon_q <= 1'b1;
      end else if (paused_q && rx_data && !send_output_held_flag_q && late_q != 3'h7) begin
        // count data arriving after our output_held_flag went out
        late_q <= late_q + 3'h1;
      end
      // a request ends once its character is taken
      if (tx_done) begin
        if (tx_q.data == OUTPUT_HELD_FLAG_CHAR) begin
          send_output_held_flag_q <= 1'b0;
        end else if (tx_q.data == XON_CHAR) begin
          send_xon_q <= 1'b0;
        end
      end
    end
  end

  // transmit mux: flow chars bypass the hold
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_q <= '0;
      txr_q <= 1'b1;
    end else if (ce_in) begin
      if (!tx_q.valid || !tx_busy_in) begin
        // flow characters jump the queue and ignore the hold
        if (send_output_held_flag_q && !(tx_q.valid && tx_q.data == OUTPUT_HELD_FLAG_CHAR)) begin
          tx_q <= '{valid: 1'b1, data: OUTPUT_HELD_FLAG_CHAR};
        end else if (send_xon_q && !(tx_q.valid && tx_q.data == XON_CHAR)) begin
          tx_q <= '{valid: 1'b1, data: XON_CHAR};
        end else if (tx_data_in.valid && !held_q) begin
          tx_q <= tx_data_in;
        end else begin
          // empty slot when nothing may go out
          tx_q <= '0;
        end
      end
      // ready only when nothing blocks ordinary data
      txr_q <= !held_q && !send_output_held_flag_q && !send_xon_q;
    end
  end

  // sticky serial error, cleared on debug off-to-on
  // a set in the same cycle wins over the clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_q <= 1'b0;
    end else if (ce_in) begin
      if (rx_err_in) begin
        err_q <= 1'b1;
      end else if (rx_data && level_q == DEPTH_W) begin
        err_q <= 1'b1;
      end else if (late_hit) begin
        err_q <= 1'b1;
      end else if (ctrl_wr && avm_writedata[CTRL_DEBUG_BIT] && !debug_q) begin
        err_q <= 1'b0;
      end
    end
  end

  // command trace ring
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_idx_q <= 4'h0;
    end else if (ce_in && new_char) begin
      // ring index wraps at the trace depth
      wr_idx_q <= wr_idx_q + 4'h1;
    end
  end

  // one flop byte per slot, written at the ring index
  for (genvar i = 0; i < TRACE_DEPTH; i++) begin : g_trace
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        trace_q[i] <= 8'h00;
      end else if (ce_in && new_char && wr_idx_q == 4'(i)) begin
        trace_q[i] <= cmd_char.data;
      end
    end
  end

  // avalon slave: one wait cycle, then ack
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      debug_q <= 1'b0;
      menu_q <= 2'h0;
      rdata_q <= 32'h0;
    end else if (ce_in) begin
      // ack high for one cycle per taken request
      ack_q <= (avm_read || avm_write) && !ack_q;
      // register writes land at the taking edge
      if (ctrl_wr) begin
        debug_q <= avm_writedata[CTRL_DEBUG_BIT];
        menu_q <= avm_writedata[CTRL_MENU_LSB +: 2];
      end
      // read data captured for the answer cycle
      if (avm_read && !ack_q) begin
        if (avm_address == ADDR_CTRL) begin
          rdata_q <= {29'h0, menu_q, debug_q};
        end else if (avm_address == ADDR_STATUS) begin
          // level above the eight flags, remote flag highest
          rdata_q <= {16'h0, level_q,
                      remote_q, lockout_q, att_q, lis_q,
                      tlk_q, err_q, held_q, paused_q};
        end else if (avm_address >= ADDR_TRACE_BASE
                     && avm_address < ADDR_TRACE_BASE + 4'h4) begin
          // four trace bytes per word, lowest slot in the low byte
          rdata_q <= {trace_q[{trace_word, 2'h3}],
                      trace_q[{trace_word, 2'h2}],
                      trace_q[{trace_word, 2'h1}],
                      trace_q[{trace_word, 2'h0}]};
        end else begin
          rdata_q <= 32'h0;
        end
      end
    end
  end

  // waitrequest drops in the cycle after the request is taken
  // it must answer within the cycle, so it alone is not a flop
  assign avm_waitrequest = (avm_read || avm_write) && !ack_q;
  // registered outputs straight from their flops
  assign avm_readdata = rdata_q;
  assign panel_keys_out = keys_q;
  assign remote_lamp_out = lamp_q;
  // status shown independent of menu while debug on
  assign status_out = '{
    remote: remote_q,
    lockout: lockout_q,
    attention: att_q,
    listen: lis_q,
    talk: tlk_q,
    serial_error_flag: err_q,
    output_held_flag: held_q,
    input_paused_flag: paused_q
  };
  assign status_visible_out = debug_q;
  // serial side outputs
  assign tx_char_out = tx_q;
  assign tx_ready_out = txr_q;
  assign rx_level_out = level_q;
endmodule

// ==== test/rlfc_core_sva.sv ====
`timescale 1ns/1ps
module rlfc_core_sva import rlfc_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic ren_in,
  input wire logic atn_n_in,
  input wire logic [9:0] panel_keys_in,
  input wire rlfc_pkg::rlfc_char_t rx_char_in,
  input wire logic rx_err_in,
  input wire logic [3:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic avm_waitrequest,
  input wire logic [9:0] panel_keys_out,
  input wire logic remote_lamp_out,
  input wire rlfc_pkg::rlfc_status_t status_out,
  input wire logic [7:0] rx_level_out
);
  logic lk;
  // lockout only bites together with remote
  assign lk = status_out.lockout && status_out.remote;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_output_held_flag; rx_char_in.valid && rx_char_in.data == OUTPUT_HELD_FLAG_CHAR; endsequence
  sequence s_xon; rx_char_in.valid && rx_char_in.data == XON_CHAR; endsequence
  sequence s_ans; avm_waitrequest ##1 !avm_waitrequest; endsequence
  property p_gate; lk ##1 lk |-> panel_keys_out == ($past(panel_keys_in) & 10'h01f); endproperty
  a_gate: assert property (p_gate) else $error("keys not gated");
  property p_pass; !lk ##1 !lk |-> panel_keys_out == $past(panel_keys_in); endproperty
  a_pass: assert property (p_pass) else $error("keys not passed");
  property p_rel; !ren_in |=> !status_out.lockout; endproperty
  a_rel: assert property (p_rel) else $error("lockout kept");
  property p_lamp; lk ##1 lk |-> remote_lamp_out; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp dark");
  property p_atn; ce_in |=> status_out.attention == !$past(atn_n_in); endproperty
  a_atn: assert property (p_atn) else $error("attention wrong");
  property p_held; s_output_held_flag |=> status_out.output_held_flag; endproperty
  a_held: assert property (p_held) else $error("output not held");
  property p_resume; s_xon |=> !status_out.output_held_flag; endproperty
  a_resume: assert property (p_resume) else $error("output not resumed");
  property p_pause; rx_level_out >= FIFO_DEPTH - 3 |-> ##[0:1] status_out.input_paused_flag;
  endproperty
  a_pause: assert property (p_pause) else $error("no pause");
  property p_err; rx_err_in |=> status_out.serial_error_flag; endproperty
  a_err: assert property (p_err) else $error("error not set");
  property p_stick; status_out.serial_error_flag && !(avm_write && avm_address == ADDR_CTRL)
    |=> status_out.serial_error_flag; endproperty
  a_stick: assert property (p_stick) else $error("error dropped");
  property p_bus; $rose(avm_read) |-> s_ans; endproperty
  a_bus: assert property (p_bus) else $error("read answer late");
endmodule
bind rlfc_core rlfc_core_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.clk_in, .rstn_in, .ce_in,
  .ren_in, .atn_n_in, .panel_keys_in, .rx_char_in, .rx_err_in, .avm_address, .avm_read,
  .avm_write, .avm_waitrequest, .panel_keys_out, .remote_lamp_out, .status_out, .rx_level_out);

// ==== test/rlfc_host.sv ====
`timescale 1ns/1ps
module rlfc_host (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic obey_in,
  input wire rlfc_pkg::rlfc_char_t inj_in,
  input wire rlfc_pkg::rlfc_char_t tx_char_in,
  output rlfc_pkg::rlfc_char_t rx_char_out,
  output logic tx_busy_out
);
  import rlfc_pkg::*;
  logic [3:0] cnt_q;
  logic paused_q;
  // pacing taken from device output_held_flag and xon
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      paused_q <= 1'b0;
    end else if (tx_char_in.valid && !tx_busy_out && tx_char_in.data inside {XON_CHAR, OUTPUT_HELD_FLAG_CHAR})
    begin
      paused_q <= (tx_char_in.data == OUTPUT_HELD_FLAG_CHAR);
    end
  end
  // sender, every other cycle, honours pause unless told not to
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 4'h0;
      rx_char_out <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (inj_in.valid) rx_char_out <= inj_in;
      else rx_char_out <= '{go_in && cnt_q[0] && !(obey_in && paused_q), {4'h4, cnt_q}};
    end
  end
  assign tx_busy_out = cnt_q[2]; // slow half the time
endmodule

// ==== test/remote_lockout_and_flow_control_test.sv ====
`timescale 1ns/1ps
module remote_lockout_and_flow_control_test;
  import rlfc_pkg::*;
  logic clk_in, rstn_in, ren_in, atn_n_in, listen_addr_in, talk_addr_in, rx_err_in, rx_pop_in;
  logic go, obey, avm_read, avm_write, avm_waitrequest, remote_lamp_out, tx_busy_in;
  logic status_visible_out, tx_ready_out;
  rlfc_msg_t bus_msg_in;
  rlfc_char_t bus_char_in, rx_char_in, inj, tx_data_in, tx_char_out;
  logic [9:0] panel_keys_in, panel_keys_out;
  logic [3:0] avm_address;
  logic [31:0] avm_writedata, avm_readdata;
  logic [7:0] rx_level_out;
  rlfc_status_t status_out;
  logic [31:0] qe[$], qm[$];
  int n_mismatch, checks;
  rlfc_core #(.FIFO_DEPTH(16)) dut_u (.clk_in, .rstn_in, .ce_in(1'b1), .ren_in, .atn_n_in,
    .listen_addr_in, .talk_addr_in, .bus_msg_in, .bus_char_in, .panel_keys_in, .rx_char_in,
    .rx_err_in, .rx_pop_in, .tx_busy_in, .tx_data_in, .avm_address, .avm_read, .avm_write,
    .avm_writedata, .avm_readdata, .avm_waitrequest, .panel_keys_out, .remote_lamp_out,
    .status_out, .status_visible_out, .tx_char_out, .tx_ready_out, .rx_level_out);
  rlfc_host host_u (.clk_in, .rstn_in, .go_in(go), .obey_in(obey), .inj_in(inj),
    .tx_char_in(tx_char_out), .rx_char_out(rx_char_in), .tx_busy_out(tx_busy_in));
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic cmp(input string n, input logic [31:0] e, m, g);
    checks++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e & m, g & m);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    avm_address <= a;
    avm_writedata <= d;
    avm_read <= r;
    avm_write <= !r;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (avm_waitrequest !== 1'b0 && i < 20);
    if (avm_waitrequest !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    avm_read <= 0;
    avm_write <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
    qe.push_back(e);
    qm.push_back(m);
    bus(1, a, 0);
  endtask
  task automatic pulse_msg(input rlfc_msg_t m);
    @(posedge clk_in);
    bus_msg_in <= m;
    @(posedge clk_in);
    bus_msg_in <= RLFC_MSG_NONE;
  endtask
  task automatic inject(input logic [7:0] c);
    @(posedge clk_in);
    inj <= '{1'b1, c};
    @(posedge clk_in);
    inj <= '0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic await(input int sel);
    int i;
    for (i = 0; i < 400 && !(sel ? status_out.serial_error_flag : status_out.input_paused_flag);
         i++) @(posedge clk_in);
    if (i == 400) n_mismatch++;
  endtask
  // read results compared against the oldest note
  always @(posedge clk_in) if (avm_read && avm_waitrequest === 1'b0)
    cmp("readdata", qe.pop_front(), qm.pop_front(), avm_readdata);
  // random keys and outgoing data
  always @(posedge clk_in) begin
    panel_keys_in <= 10'($urandom);
    tx_data_in <= '{1'b1, 8'h60 + 8'($urandom_range(0, 15))};
  end
  initial begin
    {rstn_in, ren_in, listen_addr_in, talk_addr_in, rx_err_in, rx_pop_in, go, obey} = '0;
    atn_n_in = 1;
    bus_msg_in = RLFC_MSG_NONE;
    {bus_char_in, inj, tx_data_in, panel_keys_in, avm_address, avm_writedata} = '0;
    {avm_read, avm_write, n_mismatch, checks} = '0;
    void'($urandom(32'h53123e5b));
    repeat (6) @(posedge clk_in);
    rstn_in <= 1;
    @(posedge clk_in);
    cmp("status", 0, 32'hff, status_out);
    cmp("tx_ready", 1, 1, tx_ready_out);
    rd(ADDR_TRACE_BASE, '1, 0);
    bus(0, 4'hf, '1);
    rd(4'hf, '1, 0);
    $display("test reset done");
    ren_in <= 1;
    listen_addr_in <= 1;
    atn_n_in <= 0;
    pulse_msg(RLFC_MSG_LLO);
    rd(ADDR_STATUS, 32'hf8, 32'hf0);
    cmp("lamp", 1, 1, remote_lamp_out);
    listen_addr_in <= 0;
    talk_addr_in <= 1;
    atn_n_in <= 1;
    rd(ADDR_STATUS, 32'h38, 32'h08);
    pulse_msg(RLFC_MSG_GTL);
    rd(ADDR_STATUS, 32'h80, 0);
    ren_in <= 0;
    rd(ADDR_STATUS, 32'h40, 0);
    $display("test bus done");
    go <= 1;
    obey <= 1;
    await(0);
    repeat (40) @(posedge clk_in);
    rd(ADDR_STATUS, 32'h07, 32'h01);
    go <= 0;
    rx_pop_in <= 1;
    repeat (10) @(posedge clk_in);
    rx_pop_in <= 0;
    repeat (30) @(posedge clk_in);
    rd(ADDR_STATUS, 32'h01, 0);
    inject(OUTPUT_HELD_FLAG_CHAR);
    rd(ADDR_STATUS, 32'h02, 32'h02);
    cmp("tx_ready", 0, 1, tx_ready_out);
    inject(XON_CHAR);
    rd(ADDR_STATUS, 32'h02, 0);
    $display("test flow done");
    obey <= 0;
    go <= 1;
    await(1);
    go <= 0;
    bus(0, ADDR_CTRL, 0);
    bus(0, ADDR_CTRL, 32'h7);
    rd(ADDR_STATUS, 32'h04, 0);
    cmp("visible", 1, 1, status_visible_out);
    rx_err_in <= 1;
    @(posedge clk_in);
    rx_err_in <= 0;
    bus(0, ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS, 32'h04, 32'h04);
    bus(0, ADDR_CTRL, 0);
    rd(ADDR_STATUS, 32'h04, 32'h04);
    bus(0, ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS, 32'h04, 0);
    $display("test error done");
    conclude();
  end
  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end
endmodule
